// >>> design/sbc_consts.vh
// register map, field positions and reset values for the connection status block
`ifndef SBC_CONSTS_VH
`define SBC_CONSTS_VH

// ----------------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------------
`define SBC_ADR_GEN_CTRL   32'h1008460c
`define SBC_ADR_NODE_NUM   32'h10084610
`define SBC_ADR_CONN_STAT  32'h10084648

// ----------------------------------------------------------------------
// connection status fields
// ----------------------------------------------------------------------
`define SBC_CS_SUMMARY     15
`define SBC_CS_BUS_RESET   13
`define SBC_CS_BUS_FAULT   12
`define SBC_CS_OUT_DROP    11
`define SBC_CS_PTR_EMPTY   10
`define SBC_CS_FOREIGN     9
`define SBC_CS_LIST_DONE   8
`define SBC_CS_MODE_LEFT   7
`define SBC_CS_LINK        6
`define SBC_CS_PEER_SEL    5
`define SBC_CS_TARGET      4
`define SBC_CS_ATTN        3
`define SBC_CS_SEL_ACT     2
`define SBC_CS_ARB_LOST    1
`define SBC_CS_ZERO        0

// ----------------------------------------------------------------------
// other fields
// ----------------------------------------------------------------------
`define SBC_GC_IRQ_GATE    0
`define SBC_NN_OVERRIDE    15
`define SBC_NN_WIDTH       3
`define SBC_NN_RESET       3'h0

// ----------------------------------------------------------------------
// interrupt presentation
// ----------------------------------------------------------------------
`define SBC_IRQ_LEVEL      5'h10
`define SBC_IRQ_VECTOR     8'hc5

`endif

// >>> design/sbc_conn_status.v
// connection status and node number registers of the storage bus port
//
// Behaviour
// - summary flag ORs bits 13:11 and 9:7
// - gated summary raises request, level 16, vector c5
// - bits 31:16 and 14 unwritable, read zero
// - peer bus reset: set flag, disconnect, interrupt
// - sticky flags write-one-clear except arbitration lost, cleared by resets
// - overflow, offset, phase error set bus fault
// - bus fault blocks all data transfer
// - reset, timeouts, target drop set output-dropped
// - pointer-empty shows receive list pointer zero
// - foreign destination buffer sets foreign flag
// - buffer completion sets done while gate on
// - storage enable cleared sets mode-left flag
// - link active flag follows connection, reset low
// - selected-by-peer flag shows being destination
// - target role flag follows role, reset low
// - attention selection sets attention flag
// - selection active held during selection
// - arbitration lost set, cleared at selection start
// - bit zero always reads zero
// - three-bit node number driven during selection
// - interrupt gate bit, cleared by resets
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/100ps
`include "sbc_consts.vh"

module sbc_conn_status #(
  parameter PTR_W = 16
) (
  // clock and reset
  input  wire             clk_sys,
  input  wire             sys_rst,
  input  wire             io_reset_line,
  // wishbone slave
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [31:0]      wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  // events from the protocol engine, one-cycle pulses
  input  wire             bus_reset_input,
  input  wire             ev_buf_overflow,
  input  wire             ev_offset_exceeded,
  input  wire             ev_illegal_phase,
  input  wire             ev_init_timeout,
  input  wire             ev_tgt_timeout,
  input  wire             ev_tgt_disconnect,
  input  wire             ev_foreign_buffer,
  input  wire             ev_buffer_done,
  input  wire             ev_attention_sel,
  input  wire             ev_arb_lost,
  input  wire             ev_sel_start,
  // levels from the protocol engine
  input  wire             storage_enable,
  input  wire             link_active_in,
  input  wire             peer_selected_in,
  input  wire             target_role_in,
  input  wire             selecting_in,
  input  wire [PTR_W-1:0] receive_list_pointer,
  input  wire [2:0]       id_jumpers,
  // to the protocol engine
  output reg              disconnect_req,
  output wire             data_block,
  output wire [2:0]       sel_node_id,
  // interrupt request
  output wire             storage_irq_line,
  output wire [4:0]       irq_level,
  output wire [7:0]       irq_vector
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  reg        bus_reset_q;
  reg        bus_fault_flag_q;
  reg        output_dropped_flag_q;
  reg        foreign_q;
  reg        list_item_done_q;
  reg        mode_left_flag_q;
  reg        attention_select_flag_q;
  reg        arbitration_lost_q;
  reg        link_active_flag_q;
  reg        selected_by_peer_q;
  reg        target_role_flag_q;
  reg        selection_active_q;
  reg        irq_gate_q;
  reg        id_override_q;
  reg  [2:0] node_number_q;
  reg        storage_enable_q;

  wire       clr_all;
  wire       wr_go;
  wire [31:0] bitmask;
  wire [31:0] w1c;
  wire       summary_irq_flag;
  wire       recv_pointer_empty;
  wire       hit_stat;
  wire       hit_node;
  wire       hit_ctrl;
  wire       fault_ev;
  wire       drop_ev;
  reg  [31:0] rd_d;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  // full 32-bit compare of the bus address with one register address
  function adr_hit;
    input [31:0] adr;
    input [31:0] reg_adr;
    begin
      adr_hit = (adr == reg_adr);
    end
  endfunction

  // sticky flag update: a set in the clearing cycle wins
  function sticky_next;
    input set_ev;
    input cur;
    input clr;
    begin
      sticky_next = set_ev | (cur & ~clr);
    end
  endfunction

  // --------------------------------------------------------------------
  // bus decode
  // --------------------------------------------------------------------
  assign clr_all  = sys_rst | io_reset_line;
  // unmapped addresses are still acked and read as zero
  assign hit_stat = adr_hit(wb_adr_i, `SBC_ADR_CONN_STAT);
  assign hit_node = adr_hit(wb_adr_i, `SBC_ADR_NODE_NUM);
  assign hit_ctrl = adr_hit(wb_adr_i, `SBC_ADR_GEN_CTRL);
  // write commits at the edge where the master samples ack
  assign wr_go    = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  // byte lanes spread to a bit mask
  assign bitmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  // ones written to the status register clear sticky bits
  assign w1c      = (wr_go & hit_stat) ? (wb_dat_i & bitmask) : 32'h00000000;

  // --------------------------------------------------------------------
  // live flags and summary
  // --------------------------------------------------------------------
  // empty pointer marks the end of the receive list
  assign recv_pointer_empty = (receive_list_pointer == {PTR_W{1'b0}});
  // summary is combinational so it drops with the last clear
  assign summary_irq_flag = bus_reset_q |           // bit 13
                            bus_fault_flag_q |      // bit 12
                            output_dropped_flag_q | // bit 11
                            foreign_q |             // bit 9
                            list_item_done_q |      // bit 8
                            mode_left_flag_q;       // bit 7
  assign storage_irq_line = summary_irq_flag & irq_gate_q;
  assign irq_level        = `SBC_IRQ_LEVEL;
  assign irq_vector       = `SBC_IRQ_VECTOR;
  // a fault freezes data movement until software clears it
  assign data_block       = bus_fault_flag_q;
  // the node number goes out on the bus while selecting
  // jumpers decide unless software override is set
  assign sel_node_id      = id_override_q ? node_number_q : id_jumpers;

  // --------------------------------------------------------------------
  // sticky flags, set wins over clear
  // --------------------------------------------------------------------
  // each flag sets on its event and clears on a written one, arbitration lost on selection start;
  // when both land in one cycle the set wins, so no event is lost

  // enable history for the mode-left edge, disconnect pulse
  always @(posedge clk_sys) begin
    if (clr_all) begin
      storage_enable_q <= 1'b0;
      disconnect_req   <= 1'b0;
    end else begin
      storage_enable_q <= storage_enable;
      disconnect_req   <= bus_reset_input;
    end
  end

  // grouped set conditions
  assign fault_ev = ev_buf_overflow | ev_offset_exceeded |
                    ev_illegal_phase;
  assign drop_ev  = bus_reset_input | ev_init_timeout |
                    ev_tgt_timeout | ev_tgt_disconnect;

  // bus reset seen from any node
  always @(posedge clk_sys) begin
    if (clr_all)
      bus_reset_q <= 1'b0;
    else
      bus_reset_q <= sticky_next(bus_reset_input, bus_reset_q,
                                 w1c[`SBC_CS_BUS_RESET]);
  end

  // protocol faults; the flag also stalls data transfer
  always @(posedge clk_sys) begin
    if (clr_all)
      bus_fault_flag_q <= 1'b0;
    else
      bus_fault_flag_q <= sticky_next(fault_ev, bus_fault_flag_q,
                                      w1c[`SBC_CS_BUS_FAULT]);
  end

  // output path dropped: bus reset, either timeout, lost target
  always @(posedge clk_sys) begin
    if (clr_all)
      output_dropped_flag_q <= 1'b0;
    else
      output_dropped_flag_q <= sticky_next(drop_ev, output_dropped_flag_q,
                                           w1c[`SBC_CS_OUT_DROP]);
  end

  // buffer bound for a foreign node, never expected
  always @(posedge clk_sys) begin
    if (clr_all)
      foreign_q <= 1'b0;
    else
      foreign_q <= sticky_next(ev_foreign_buffer, foreign_q,
                               w1c[`SBC_CS_FOREIGN]);
  end

  // buffer completion counts only while the gate is on
  always @(posedge clk_sys) begin
    if (clr_all)
      list_item_done_q <= 1'b0;
    else
      list_item_done_q <= sticky_next(ev_buffer_done & irq_gate_q,
                                      list_item_done_q,
                                      w1c[`SBC_CS_LIST_DONE]);
  end

  // falling storage enable means the port left storage mode
  always @(posedge clk_sys) begin
    if (clr_all)
      mode_left_flag_q <= 1'b0;
    else
      mode_left_flag_q <= sticky_next(storage_enable_q & ~storage_enable,
                                      mode_left_flag_q,
                                      w1c[`SBC_CS_MODE_LEFT]);
  end

  // selection with attention, cleared by writing one
  always @(posedge clk_sys) begin
    if (clr_all)
      attention_select_flag_q <= 1'b0;
    else
      attention_select_flag_q <= sticky_next(ev_attention_sel,
                                             attention_select_flag_q,
                                             w1c[`SBC_CS_ATTN]);
  end

  // lost arbitration; a loss with a new selection is kept
  always @(posedge clk_sys) begin
    if (clr_all)
      arbitration_lost_q <= 1'b0;
    else
      arbitration_lost_q <= sticky_next(ev_arb_lost, arbitration_lost_q,
                                        ev_sel_start);
  end

  // --------------------------------------------------------------------
  // live connection flags, registered
  // --------------------------------------------------------------------
  // levels are shown one cycle late, through a flop each

  // connection to another node, cleared at reset
  always @(posedge clk_sys) begin
    if (clr_all)
      link_active_flag_q <= 1'b0;
    else
      link_active_flag_q <= link_active_in;
  end

  // another node picked this port as destination
  always @(posedge clk_sys) begin
    if (clr_all)
      selected_by_peer_q <= 1'b0;
    else
      selected_by_peer_q <= peer_selected_in;
  end

  // acting as target in the current transfer
  always @(posedge clk_sys) begin
    if (clr_all)
      target_role_flag_q <= 1'b0;
    else
      target_role_flag_q <= target_role_in;
  end

  // selection in progress; a stuck bit points at a missing target
  always @(posedge clk_sys) begin
    if (clr_all)
      selection_active_q <= 1'b0;
    else
      selection_active_q <= selecting_in;
  end

  // --------------------------------------------------------------------
  // control and node number registers
  // --------------------------------------------------------------------
  // interrupt gate in the general control register
  always @(posedge clk_sys) begin
    if (clr_all)
      irq_gate_q <= 1'b0;
    else if (wr_go && hit_ctrl && wb_sel_i[0])
      irq_gate_q <= wb_dat_i[`SBC_GC_IRQ_GATE];
  end

  // override bit; the number is writable only while it is already on
  always @(posedge clk_sys) begin
    if (clr_all) begin
      id_override_q <= 1'b0;
      node_number_q <= `SBC_NN_RESET;
    end else if (wr_go && hit_node) begin
      if (wb_sel_i[1])
        id_override_q <= wb_dat_i[`SBC_NN_OVERRIDE];
      if (wb_sel_i[0] && id_override_q)
        node_number_q <= wb_dat_i[2:0];
    end
  end

  // --------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------
  // read data of the addressed register, stable zero elsewhere
  always @* begin
    rd_d = 32'h00000000; // unused bits read zero
    if (hit_stat) begin
      rd_d[`SBC_CS_SUMMARY]   = summary_irq_flag;
      rd_d[`SBC_CS_BUS_RESET] = bus_reset_q;
      rd_d[`SBC_CS_BUS_FAULT] = bus_fault_flag_q;
      rd_d[`SBC_CS_OUT_DROP]  = output_dropped_flag_q;
      rd_d[`SBC_CS_PTR_EMPTY] = recv_pointer_empty;
      rd_d[`SBC_CS_FOREIGN]   = foreign_q;
      rd_d[`SBC_CS_LIST_DONE] = list_item_done_q;
      rd_d[`SBC_CS_MODE_LEFT] = mode_left_flag_q;
      rd_d[`SBC_CS_LINK]      = link_active_flag_q;
      rd_d[`SBC_CS_PEER_SEL]  = selected_by_peer_q;
      rd_d[`SBC_CS_TARGET]    = target_role_flag_q;
      rd_d[`SBC_CS_ATTN]      = attention_select_flag_q;
      rd_d[`SBC_CS_SEL_ACT]   = selection_active_q;
      rd_d[`SBC_CS_ARB_LOST]  = arbitration_lost_q;
      rd_d[`SBC_CS_ZERO]      = 1'b0;
    end else if (hit_node) begin
      rd_d[`SBC_NN_OVERRIDE] = id_override_q;
      rd_d[2:0] = id_override_q ? node_number_q : ~id_jumpers;
    end else if (hit_ctrl) begin
      rd_d[`SBC_GC_IRQ_GATE] = irq_gate_q;
    end
  end

  // --------------------------------------------------------------------
  // ack and read data, one wait state
  // --------------------------------------------------------------------
  // ack one cycle after the request, dropped the cycle after
  always @(posedge clk_sys) begin
    if (sys_rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
  end

  // read data captured with the request, held until the next one
  always @(posedge clk_sys) begin
    if (sys_rst)
      wb_dat_o <= 32'h00000000;
    else if (wb_cyc_i & wb_stb_i & ~wb_ack_o)
      wb_dat_o <= rd_d;
  end

endmodule // sbc_conn_status

// >>> testbench/sbc_props.sv
// port checker for the connection status block
`timescale 1ns/100ps
module sbc_props (
  // clock and resets
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic io_reset_line,
  // register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  // events and outputs
  input wire logic bus_reset_input,
  input wire logic ev_buf_overflow,
  input wire logic ev_offset_exceeded,
  input wire logic ev_illegal_phase,
  input wire logic disconnect_req,
  input wire logic data_block,
  input wire logic storage_irq_line,
  input wire logic [4:0] irq_level,
  input wire logic [7:0] irq_vector
);
  wire req = wb_cyc_i && wb_stb_i;
  wire fault_ev = ev_buf_overflow | ev_offset_exceeded | ev_illegal_phase;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst || io_reset_line);
  // ---------
  // properties
  // ---------
  a_ack_next: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_disc_now: assert property (bus_reset_input |=> disconnect_req)
    else $error("no disconnect after bus reset");
  a_disc_cause: assert property (disconnect_req |-> $past(bus_reset_input))
    else $error("disconnect without bus reset");
  a_fault_set: assert property (fault_ev |=> data_block)
    else $error("fault event did not block data");
  a_fault_cause: assert property ($rose(data_block) |-> $past(fault_ev))
    else $error("data blocked without fault");
  a_fault_holds: assert property (
    data_block && !(wb_we_i && wb_ack_o) |=> data_block)
    else $error("fault flag dropped without write");
  a_irq_code: assert property (irq_level == 5'h10 && irq_vector == 8'hc5)
    else $error("wrong interrupt level or vector");
  cover property (bus_reset_input ##1 disconnect_req);
  cover property ($fell(data_block));
  cover property (storage_irq_line ##1 !storage_irq_line);
endmodule // sbc_props

bind sbc_conn_status sbc_props sbc_props_inst (.clk_sys, .sys_rst,
  .io_reset_line, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .bus_reset_input, .ev_buf_overflow, .ev_offset_exceeded,
  .ev_illegal_phase, .disconnect_req, .data_block, .storage_irq_line,
  .irq_level, .irq_vector);

// >>> testbench/sbc_peer_model.sv
// far-side bus nodes: event pulses, prompt or one cycle late
`timescale 1ns/100ps
module sbc_peer_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // requests from the bench
  input  wire logic [11:0] ev_req,
  input  wire logic        slow,
  // pulses toward the block
  output logic      [11:0] pulse_q
);
  logic [11:0] late_q;
  // bit 0 is a bus reset by some node, others engine events
  always @(posedge clk_sys) begin
    late_q  <= sys_rst ? 12'h000 : (slow ? ev_req : 12'h000);
    pulse_q <= sys_rst ? 12'h000 : ((slow ? 12'h000 : ev_req) | late_q);
  end
endmodule // sbc_peer_model

// >>> testbench/tb_top.sv
// self-checking bench for the connection status block
`timescale 1ns/100ps
`include "sbc_consts.vh"
module tb_top;
  logic clk_sys = 0, sys_rst = 1, io_rst = 0, cyc = 0, we = 0, slow = 0;
  logic st_en = 1, link = 0, peer = 0, target_role_flag = 0, sel = 0;
  logic [31:0] adr = 0, wdat = 0, dat_o, rdat;
  logic ack, disc, blk, irq;
  logic [2:0] nid;
  logic [4:0] lvl;
  logic [7:0] vec;
  logic [15:0] ptr = 0;
  logic [11:0] req = 0, pul;
  int errors = 0, n_tests = 0, cyc_n = 0;
  // expected status after each event
  logic [31:0] exp_t [11] = '{32'ha800, 32'h9000, 32'h9000, 32'h9000,
    32'h8800, 32'h8800, 32'h8800, 32'h8200, 32'h8100, 32'h0008, 32'h0002};
  sbc_conn_status sbc_conn_status_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .io_reset_line(io_rst), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .bus_reset_input(pul[0]), .ev_buf_overflow(pul[1]),
    .ev_offset_exceeded(pul[2]), .ev_illegal_phase(pul[3]),
    .ev_init_timeout(pul[4]), .ev_tgt_timeout(pul[5]),
    .ev_tgt_disconnect(pul[6]), .ev_foreign_buffer(pul[7]),
    .ev_buffer_done(pul[8]), .ev_attention_sel(pul[9]),
    .ev_arb_lost(pul[10]), .ev_sel_start(pul[11]), .storage_enable(st_en),
    .link_active_in(link), .peer_selected_in(peer), .target_role_in(target_role_flag),
    .selecting_in(sel), .receive_list_pointer(ptr), .id_jumpers(3'h5),
    .disconnect_req(disc), .data_block(blk), .sel_node_id(nid),
    .storage_irq_line(irq), .irq_level(lvl), .irq_vector(vec));
  sbc_peer_model sbc_peer_model_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .ev_req(req), .slow(slow), .pulse_q(pul));
  initial forever #2 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys) if (++cyc_n == 20000) begin
    errors++;
    final_report;
  end
  task automatic check(string name, logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s exp %h seen %h", name, exp, seen);
    end
  endtask
  // classic single cycle, held until ack sampled
  task automatic bus(logic w, logic [31:0] a, d);
    cyc <= 1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_sys); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0; we <= 0;
    @(posedge clk_sys);
  endtask
  task automatic rd(logic [31:0] a, exp, string name);
    bus(0, a, 0);
    check(name, rdat, exp);
  endtask
  task automatic fire(int i);
    req <= 12'h001 << i;
    @(posedge clk_sys);
    req <= 0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic t_events;
    ptr <= 16'h0040;
    bus(1, `SBC_ADR_GEN_CTRL, 1);
    for (int i = 0; i < 11; i++) begin
      slow <= i[0];
      fire(i);
      rd(`SBC_ADR_CONN_STAT, exp_t[i], "status");
      check("irq", irq, exp_t[i][15]);
      if (i inside {[1:3]}) check("block", blk, 1);
      if (i == 10) fire(11);
      bus(1, `SBC_ADR_CONN_STAT, 32'hffffffff);
      rd(`SBC_ADR_CONN_STAT, 0, "cleared");
      check("irq off", irq, 0);
      check("unblock", blk, 0);
    end
  endtask
  task automatic t_misc;
    bus(1, `SBC_ADR_GEN_CTRL, 0);
    fire(8);
    rd(`SBC_ADR_CONN_STAT, 0, "done gated");
    fire(1);
    check("irq gated", irq, 0);
    bus(1, `SBC_ADR_CONN_STAT, 32'hffffffff);
    link <= 1; peer <= 1; target_role_flag <= 1; sel <= 1;
    repeat (2) @(posedge clk_sys);
    rd(`SBC_ADR_CONN_STAT, 32'h0074, "levels");
    link <= 0; peer <= 0; target_role_flag <= 0; sel <= 0; st_en <= 0;
    repeat (2) @(posedge clk_sys);
    rd(`SBC_ADR_CONN_STAT, 32'h8080, "mode left");
    bus(1, `SBC_ADR_NODE_NUM, 32'h8003);
    rd(`SBC_ADR_NODE_NUM, 32'h8000, "node locked");
    bus(1, `SBC_ADR_NODE_NUM, 32'h8003);
    rd(`SBC_ADR_NODE_NUM, 32'h8003, "node ovr");
    check("sel id", nid, 3);
    bus(1, `SBC_ADR_NODE_NUM, 0);
    rd(`SBC_ADR_NODE_NUM, 2, "node jmp");
    check("sel id", nid, 5);
    ptr <= 0; st_en <= 1;
    bus(1, `SBC_ADR_GEN_CTRL, 1);
    io_rst <= 1;
    @(posedge clk_sys);
    io_rst <= 0;
    @(posedge clk_sys);
    rd(`SBC_ADR_CONN_STAT, 32'h0400, "io reset");
    rd(`SBC_ADR_GEN_CTRL, 0, "gate io");
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 0;
    @(posedge clk_sys);
    rd(`SBC_ADR_CONN_STAT, 32'h0400, "reset stat");
    rd(`SBC_ADR_GEN_CTRL, 0, "reset gate");
    rd(`SBC_ADR_NODE_NUM, 2, "reset node");
    rd(32'h10084600, 0, "unmapped");
    check("vector", {lvl, vec}, 13'h10c5);
    t_events;
    t_misc;
    final_report;
  end
endmodule // tb_top
